// ==== include/uim_map.svh ====
/*
 * register offsets, field positions and reset values of the usb interface machine
 * register block. assumes a 32-bit peripheral access port with byte offsets.
 */
`ifndef UIM_MAP_SVH
`define UIM_MAP_SVH

`define UIM_OFF_IFM_CTRL      8'h04
`define UIM_OFF_DEV_ADDR      8'h08
`define UIM_OFF_OTG_CTRL      8'h10
`define UIM_OFF_OTG_FLAGS     8'h14
`define UIM_OFF_SERIAL_CTRL   8'h18
`define UIM_OFF_LINE_FLAGS    8'h1C
`define UIM_OFF_HOLD_SEL      8'h20
`define UIM_OFF_PORT_MASKS    8'h24
`define UIM_OFF_FRAME_CNT     8'h28
`define UIM_OFF_LAST_PID      8'h2C
`define UIM_OFF_LAST_EP       8'h30
`define UIM_OFF_EP_SPECIAL    8'h34
`define UIM_OFF_OTG_MASK      8'h38
`define UIM_OFF_POWER_SIG     8'h3C

`define UIM_LSD_EN_BIT        2
`define UIM_SER_CTRL_RST      4'h2
`define UIM_FLAG_TOKEN        6
`define UIM_FLAG_SE0          5
`define UIM_FLAG_K            4
`define UIM_FLAG_J            3
`define UIM_FLAG_CRC16        2
`define UIM_FLAG_RXACT        1
`define UIM_FLAG_RXERR        0
`define UIM_EP_SPECIAL_OR     5'h10
`define UIM_LS_SE0            2'h0
`define UIM_LS_J              2'h1
`define UIM_LS_K              2'h2

`endif

// ==== include/uim_pkg.sv ====
/*
 * types shared by the usb interface machine register block.
 * assumes the map header supplies all numeric constants.
 */
package uim_pkg;

   typedef struct packed {
      logic ext_vbus_ind;
      logic ext_vbus_drv;
      logic chrg_vbus;
      logic dischrg_vbus;
      logic dm_pulldown;
      logic dp_pulldown;
      logic id_pullup;
   } uim_otg_ctrl_t;

   typedef struct packed {
      logic bvalid;
      logic idgnd;
      logic hostdis;
      logic vbusvld;
      logic sessvld;
      logic sessend;
   } uim_otg_stat_t;

   typedef struct packed {
      logic tx_se0;
      logic tx_data;
      logic tx_enable_n;
      logic fsls_serial;
   } uim_serial_ctrl_t;

   typedef struct packed {
      logic       valid;
      logic [3:0] pid;
      logic [3:0] endp;
      logic [6:0] addr;
      logic       crc5_ok;
      logic       pid_ok;
   } uim_token_t;

   typedef enum logic [2:0] {
      UIM_RX_IDLE   = 3'b001,
      UIM_RX_ACTIVE = 3'b010,
      UIM_RX_DONE   = 3'b100
   } uim_rx_state_t;

endpackage : uim_pkg

// ==== rtl/uim_regs.sv ====
/*
 * usb interface machine register block: on-the-go control and status, serial line
 * control, line and error flags with hold select and flag ports, frame counter,
 * last packet id and endpoint capture, special endpoint marking.
 * assumes the packet decoder reports one token/data result per pulse on the core
 * clock; phy status and line inputs are asynchronous and synchronised here.
 */
`include "uim_map.svh"

// Notes on behaviour
// - bits 7,6 select external vbus modes
// - bits 4..1 drive charge, discharge, pulldowns
// - bit 0 drives id pullup
// - otg flags read live phy status
// - serial bits 6..4 read receive lines
// - serial bits 3,2,0 drive tx outputs
// - serial bit 1 resets high, low enables
// - non-held flags 6..2 clear at next packet
// - flag 6 on good matching token
// - flags 5..3 on se0, k, j
// - flag 2 on data crc16 failure
// - flags 1,0 follow rxactive, rxerror unless held
// - held flags clear by writing one
// - masked flags or onto flag ports
// - eleven-bit frame counter, one field at 0x28
// - capture last packet id
// - capture last endpoint with valid bit
// - special endpoints delivered ored with 0x10
// - address register filters tokens
// - symbol detection needs decoder enable
module uim_regs
   import uim_pkg::*;
(
   // clock, reset, enable
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   input  wire logic             clk_en_i,
   // peripheral register port
   input  wire logic             reg_wr_i,
   input  wire logic             reg_rd_i,
   input  wire logic [7:0]       reg_addr_i,
   input  wire logic [31:0]      reg_wdata_i,
   output logic      [31:0]      reg_rdata_o,
   // phy status and line inputs (asynchronous)
   input  wire uim_otg_stat_t    otg_stat_i,
   input  wire logic             rx_rcv_i,
   input  wire logic             rx_dm_i,
   input  wire logic             rx_dp_i,
   input  wire logic [1:0]       line_state_i,
   input  wire logic             utmi_rxactive_i,
   input  wire logic             utmi_rxerror_i,
   // packet decoder results (core clock)
   input  wire uim_token_t       token_i,
   input  wire logic             data_done_i,
   input  wire logic             data_crc16_bad_i,
   // phy control outputs
   output uim_otg_ctrl_t         otg_ctrl_o,
   output uim_serial_ctrl_t      serial_ctrl_o,
   // flag ports
   output logic                  flag_port_a_o,
   output logic                  flag_port_b_o,
   output logic                  flag_port_c_o,
   output logic                  flag_port_d_o,
   // receive endpoint delivery
   output logic                  rx_ep_valid_o,
   output logic      [4:0]       rx_ep_o
);

   function automatic logic hit(input logic [6:0] flags, input logic [7:0] mask);
      hit = |(flags & mask[6:0]);
   endfunction : hit

   // synchronisers for everything arriving from the phy
   localparam int SW = 13;
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   wire  [SW-1:0] async_in = {otg_stat_i, rx_rcv_i, rx_dm_i, rx_dp_i, line_state_i,
                              utmi_rxactive_i, utmi_rxerror_i};

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (clk_en_i) begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
      end
   end

   uim_otg_stat_t otg_stat_s;
   logic          rx_rcv_s;
   logic          rx_dm_s;
   logic          rx_dp_s;
   logic [1:0]    line_state_s;
   logic          rxactive_s;
   logic          rxerror_s;
   assign {otg_stat_s, rx_rcv_s, rx_dm_s, rx_dp_s, line_state_s, rxactive_s, rxerror_s}
      = sync2_q;

   // register storage
   logic [7:0]       ifm_ctrl_q;
   logic [6:0]       dev_addr_q;
   uim_otg_ctrl_t    otg_ctrl_q;
   uim_serial_ctrl_t serial_ctrl_q;
   logic [6:0]       hold_sel_q;
   logic [31:0]      port_masks_q;
   logic [10:0]      frame_cnt_q;
   logic [15:0]      ep_special_q;
   logic [31:0]      otg_mask_q;
   logic [8:0]       power_sig_q;
   logic [6:0]       flags_q;
   logic [6:0]       flags_d;
   logic [3:0]       last_pid_q;
   logic [3:0]       last_ep_q;
   logic             last_ep_valid_q;
   uim_rx_state_t    rx_state_q;

   wire wr = reg_wr_i & clk_en_i;
   function automatic logic wr_at(input logic [7:0] off);
      wr_at = wr && (reg_addr_i == off);
   endfunction : wr_at

   // writable control registers; reserved bits are dropped on write
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ifm_ctrl_q    <= '0;
         dev_addr_q    <= '0;
         otg_ctrl_q    <= '0;
         serial_ctrl_q <= `UIM_SER_CTRL_RST;
         hold_sel_q    <= '0;
         port_masks_q  <= '0;
         ep_special_q  <= '0;
         otg_mask_q    <= '0;
         power_sig_q   <= '0;
      end else begin
         if (wr_at(`UIM_OFF_IFM_CTRL)) begin
            ifm_ctrl_q <= reg_wdata_i[7:0] & 8'hF7;
         end
         if (wr_at(`UIM_OFF_DEV_ADDR)) begin
            dev_addr_q <= reg_wdata_i[6:0];
         end
         if (wr_at(`UIM_OFF_OTG_CTRL)) begin
            otg_ctrl_q <= {reg_wdata_i[7:6], reg_wdata_i[4:0]};
         end
         if (wr_at(`UIM_OFF_SERIAL_CTRL)) begin
            serial_ctrl_q <= reg_wdata_i[3:0];
         end
         if (wr_at(`UIM_OFF_HOLD_SEL)) begin
            hold_sel_q <= reg_wdata_i[6:0];
         end
         if (wr_at(`UIM_OFF_PORT_MASKS)) begin
            port_masks_q <= reg_wdata_i;
         end
         if (wr_at(`UIM_OFF_EP_SPECIAL)) begin
            ep_special_q <= reg_wdata_i[15:0];
         end
         if (wr_at(`UIM_OFF_OTG_MASK)) begin
            otg_mask_q <= reg_wdata_i;
         end
         if (wr_at(`UIM_OFF_POWER_SIG)) begin
            power_sig_q <= reg_wdata_i[8:0];
         end
      end
   end

   // packet boundary tracking from rxactive
   wire pkt_start = (rx_state_q != UIM_RX_ACTIVE) && rxactive_s;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_state_q <= UIM_RX_IDLE;
      end else if (clk_en_i) begin
         case (rx_state_q)
            UIM_RX_IDLE: begin
               if (rxactive_s) begin
                  rx_state_q <= UIM_RX_ACTIVE;
               end
            end
            UIM_RX_ACTIVE: begin
               // the done state lets a packet that follows at once count as new
               if (!rxactive_s) begin
                  rx_state_q <= UIM_RX_DONE;
               end
            end
            UIM_RX_DONE: begin
               if (rxactive_s) begin
                  rx_state_q <= UIM_RX_ACTIVE;
               end else begin
                  rx_state_q <= UIM_RX_IDLE;
               end
            end
            default: begin
               // an illegal code falls back to idle rather than locking up
               rx_state_q <= UIM_RX_IDLE;
            end
         endcase
      end
   end

   // token accepted only with good crc5, good pid and our address
   wire tok_ok = token_i.valid & token_i.crc5_ok & token_i.pid_ok
                 & (token_i.addr == dev_addr_q);
   wire lsd_en = ifm_ctrl_q[`UIM_LSD_EN_BIT];

   logic [6:0] ev;
   always_comb begin
      ev                  = '0;
      ev[`UIM_FLAG_TOKEN] = tok_ok;
      ev[`UIM_FLAG_SE0]   = lsd_en && (line_state_s == `UIM_LS_SE0);
      ev[`UIM_FLAG_K]     = lsd_en && (line_state_s == `UIM_LS_K);
      ev[`UIM_FLAG_J]     = lsd_en && (line_state_s == `UIM_LS_J);
      ev[`UIM_FLAG_CRC16] = data_done_i & data_crc16_bad_i;
      ev[`UIM_FLAG_RXACT] = rxactive_s;
      ev[`UIM_FLAG_RXERR] = rxerror_s;
   end

   // flags: held bits keep set until write-one, others clear at packet start and
   // the live-level bits simply follow their inputs
   logic [6:0] clr_w1;
   assign clr_w1 = wr_at(`UIM_OFF_LINE_FLAGS) ? reg_wdata_i[6:0] : 7'h00;

   // for normal flags a set beats the packet-start clear so no event is lost
   always_comb begin
      flags_d = flags_q;
      for (int i = 0; i < 7; i++) begin
         if (hold_sel_q[i]) begin
            if (clr_w1[i]) begin
               flags_d[i] = 1'b0;
            end else if (ev[i]) begin
               flags_d[i] = 1'b1;
            end
         end else if (i == `UIM_FLAG_RXACT || i == `UIM_FLAG_RXERR) begin
            flags_d[i] = ev[i];
         end else if (ev[i]) begin
            flags_d[i] = 1'b1;
         end else if (pkt_start || clr_w1[i]) begin
            flags_d[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_q <= '0;
      end else if (clk_en_i) begin
         flags_q <= flags_d;
      end
   end

   // flag ports are registered from the next flag values (flags_d) and the masks
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flag_port_a_o <= 1'b0;
         flag_port_b_o <= 1'b0;
         flag_port_c_o <= 1'b0;
         flag_port_d_o <= 1'b0;
      end else if (clk_en_i) begin
         flag_port_a_o <= hit(flags_d, port_masks_q[7:0]);
         flag_port_b_o <= hit(flags_d, port_masks_q[15:8]);
         flag_port_c_o <= hit(flags_d, port_masks_q[23:16]);
         flag_port_d_o <= hit(flags_d, port_masks_q[31:24]);
      end
   end

   // frame counter: software writes win; no hardware increment is defined here
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         frame_cnt_q <= '0;
      end else if (wr_at(`UIM_OFF_FRAME_CNT)) begin
         frame_cnt_q <= reg_wdata_i[10:0];
      end
   end

   // last pid and endpoint capture on any accepted token
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         last_pid_q      <= '0;
         last_ep_q       <= '0;
         last_ep_valid_q <= 1'b0;
      end else if (clk_en_i && tok_ok) begin
         last_pid_q      <= token_i.pid;
         last_ep_q       <= token_i.endp;
         last_ep_valid_q <= 1'b1;
      end
   end

   // endpoint delivery to the receive side; the number holds after the pulse,
   // the valid pulse alone marks fresh data
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_ep_valid_o <= 1'b0;
         rx_ep_o       <= '0;
      end else if (clk_en_i) begin
         rx_ep_valid_o <= tok_ok;
         if (tok_ok) begin
            rx_ep_o <= {1'b0, token_i.endp}
                       | (ep_special_q[token_i.endp] ? `UIM_EP_SPECIAL_OR : 5'h00);
         end
      end
   end

   // phy control outputs, registered copies
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         otg_ctrl_o    <= '0;
         serial_ctrl_o <= `UIM_SER_CTRL_RST;
      end else if (clk_en_i) begin
         otg_ctrl_o    <= otg_ctrl_q;
         serial_ctrl_o <= serial_ctrl_q;
      end
   end

   // read mux; unmapped offsets and reserved bits read zero
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h0000_0000;
      case (reg_addr_i)
         `UIM_OFF_IFM_CTRL: begin
            rdata[7:0] = ifm_ctrl_q;
         end
         `UIM_OFF_DEV_ADDR: begin
            rdata[6:0] = dev_addr_q;
         end
         `UIM_OFF_OTG_CTRL: begin
            // bit 5 is a hole in the field, it reads zero
            rdata[7:0] = {otg_ctrl_q[6:5], 1'b0, otg_ctrl_q[4:0]};
         end
         `UIM_OFF_OTG_FLAGS: begin
            rdata[5:0] = otg_stat_s;
         end
         `UIM_OFF_SERIAL_CTRL: begin
            rdata[6:0] = {rx_rcv_s, rx_dm_s, rx_dp_s, serial_ctrl_q};
         end
         `UIM_OFF_LINE_FLAGS: begin
            rdata[6:0] = flags_q;
         end
         `UIM_OFF_HOLD_SEL: begin
            rdata[6:0] = hold_sel_q;
         end
         `UIM_OFF_PORT_MASKS: begin
            rdata = port_masks_q;
         end
         `UIM_OFF_FRAME_CNT: begin
            rdata[10:0] = frame_cnt_q;
         end
         `UIM_OFF_LAST_PID: begin
            rdata[3:0] = last_pid_q;
         end
         `UIM_OFF_LAST_EP: begin
            rdata[4:0] = {last_ep_valid_q, last_ep_q};
         end
         `UIM_OFF_EP_SPECIAL: begin
            rdata[15:0] = ep_special_q;
         end
         `UIM_OFF_OTG_MASK: begin
            rdata = otg_mask_q;
         end
         `UIM_OFF_POWER_SIG: begin
            rdata[8:0] = power_sig_q;
         end
         default: begin
            rdata = 32'h0000_0000;
         end
      endcase
   end

   // read data holds between reads so a slow master may take it late
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= '0;
      end else if (clk_en_i && reg_rd_i) begin
         reg_rdata_o <= rdata;
      end
   end

endmodule : uim_regs

// ==== tb/uim_phy_model.sv ====
/* transceiver model: drives status, receive and line levels.
   assumes the bench calls its tasks; levels change just after a clock edge. */
module uim_phy_model
   import uim_pkg::*;
(
   input  wire logic    core_clk_i,
   output uim_otg_stat_t otg_stat_o,
   output logic [2:0]   rx_lines_o,
   output logic [1:0]   line_state_o,
   output logic         rxactive_o,
   output logic         rxerror_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      otg_stat_o = '0;
      rx_lines_o = 3'h0;
      line_state_o = 2'h1;
      rxactive_o = 1'b0;
      rxerror_o = 1'b0;
   end
   task automatic set_lines(input logic [8:0] v);
      @(posedge core_clk_i);
      {otg_stat_o, rx_lines_o} <= v;
   endtask : set_lines
   task automatic set_ls(input logic [1:0] s);
      @(posedge core_clk_i);
      line_state_o <= s;
   endtask : set_ls
   // rising receive-active marks the start of a packet
   task automatic set_rx(input logic act, input logic err);
      @(posedge core_clk_i);
      rxactive_o <= act;
      rxerror_o <= err;
   endtask : set_rx
endmodule : uim_phy_model

// ==== tb/uim_regs_assertions.sv ====
/* port assertions for the usb interface machine register block.
   assumes one core clock and an asynchronous active-high reset. */
module uim_regs_chk
   import uim_pkg::*;
(
   input wire logic             core_clk_i,
   input wire logic             rst_i,
   input wire logic             clk_en_i,
   input wire logic             reg_wr_i,
   input wire logic             reg_rd_i,
   input wire logic [7:0]       reg_addr_i,
   input wire logic [31:0]      reg_wdata_i,
   input wire logic [31:0]      reg_rdata_o,
   input wire uim_token_t       token_i,
   input wire uim_otg_ctrl_t    otg_ctrl_o,
   input wire uim_serial_ctrl_t serial_ctrl_o,
   input wire logic             rx_ep_valid_o,
   input wire logic [4:0]       rx_ep_o
);
   timeunit 1ns;
   timeprecision 1ps;
   wire good_tok = clk_en_i && token_i.valid && token_i.crc5_ok && token_i.pid_ok;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_wr(logic [7:0] a);
      clk_en_i && reg_wr_i && reg_addr_i == a;
   endsequence
   sequence s_rd(logic [7:0] a);
      clk_en_i && reg_rd_i && reg_addr_i == a;
   endsequence
   // outputs follow the register one enabled edge later
   property p_otg;
      s_wr(8'h10) ##1 clk_en_i |-> ##1
         otg_ctrl_o == {$past(reg_wdata_i[7:6], 2), $past(reg_wdata_i[4:0], 2)};
   endproperty
   property p_ser;
      s_wr(8'h18) ##1 clk_en_i |-> ##1 serial_ctrl_o == $past(reg_wdata_i[3:0], 2);
   endproperty
   property p_unmap;
      (s_rd(8'h00) or s_rd(8'h0C) or s_rd(8'h40)) |=> reg_rdata_o == 32'h0;
   endproperty
   property p_resv;
      s_rd(8'h10) |=> reg_rdata_o[31:8] == 24'h0 && !reg_rdata_o[5];
   endproperty
   property p_hold;
      !(clk_en_i && reg_rd_i) |=> $stable(reg_rdata_o);
   endproperty
   property p_freeze;
      !clk_en_i |=> $stable(otg_ctrl_o) && $stable(serial_ctrl_o) && $stable(rx_ep_o);
   endproperty
   property p_ep_src;
      $rose(rx_ep_valid_o) |-> $past(good_tok);
   endproperty
   property p_bad_tok;
      clk_en_i && token_i.valid && !token_i.crc5_ok |=> !rx_ep_valid_o;
   endproperty
   property p_ep_val;
      good_tok ##1 rx_ep_valid_o |-> rx_ep_o[3:0] == $past(token_i.endp);
   endproperty
   a_otg: assert property (p_otg) else $error("otg outputs differ from write");
   a_ser: assert property (p_ser) else $error("serial outputs differ from write");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_resv: assert property (p_resv) else $error("reserved otg bits not zero");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
   a_ep_src: assert property (p_ep_src) else $error("endpoint pulse uncaused");
   a_bad_tok: assert property (p_bad_tok) else $error("bad token accepted");
   a_ep_val: assert property (p_ep_val) else $error("endpoint number wrong");
endmodule : uim_regs_chk

bind uim_regs uim_regs_chk u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .clk_en_i(clk_en_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .token_i(token_i),
   .otg_ctrl_o(otg_ctrl_o), .serial_ctrl_o(serial_ctrl_o),
   .rx_ep_valid_o(rx_ep_valid_o), .rx_ep_o(rx_ep_o));

// ==== tb/uim_regs_tb_top.sv ====
/* self-checking bench for the register block with a transceiver model.
   assumes synced inputs settle within four cycles. */
module uim_regs_tb_top;
   import uim_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i, rst_i, clk_en_i, reg_wr_i, reg_rd_i, data_done_i, data_crc16_bad_i;
   logic [7:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, e [9], v;
   uim_token_t token_i;
   uim_otg_stat_t stat;
   uim_otg_ctrl_t otg_ctrl_o;
   uim_serial_ctrl_t serial_ctrl_o;
   logic [2:0] rxl;
   logic [1:0] ls;
   logic rxa, rxe, pa, pb, pc, pd, epv;
   logic [4:0] ep;
   int n_errors = 0, n_tests = 0, seed = 97, cyc = 0;
   logic [7:0] offs [9] = '{8'h08, 8'h10, 8'h18, 8'h20, 8'h24, 8'h28, 8'h34, 8'h38, 8'h3C};
   logic [31:0] msk [9] = '{32'h7F, 32'hDF, 32'hF, 32'h7F, 32'hFFFFFFFF, 32'h7FF,
                            32'hFFFF, 32'hFFFFFFFF, 32'h1FF};
   uim_phy_model phy (.core_clk_i(core_clk_i), .otg_stat_o(stat), .rx_lines_o(rxl),
      .line_state_o(ls), .rxactive_o(rxa), .rxerror_o(rxe));
   uim_regs uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .otg_stat_i(stat),
      .rx_rcv_i(rxl[2]), .rx_dm_i(rxl[1]), .rx_dp_i(rxl[0]), .line_state_i(ls),
      .utmi_rxactive_i(rxa), .utmi_rxerror_i(rxe), .token_i(token_i),
      .data_done_i(data_done_i), .data_crc16_bad_i(data_crc16_bad_i),
      .otg_ctrl_o(otg_ctrl_o), .serial_ctrl_o(serial_ctrl_o), .flag_port_a_o(pa),
      .flag_port_b_o(pb), .flag_port_c_o(pc), .flag_port_d_o(pd),
      .rx_ep_valid_o(epv), .rx_ep_o(ep));
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   task automatic close_out();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge core_clk_i);
      #1 chk(reg_rdata_o, exp);
   endtask : rdc
   // special endpoint mask is fixed at 0x0008 in the token scenarios
   task automatic tok(input logic [3:0] id, input logic [3:0] n, input logic [6:0] ad,
                      input logic ok);
      logic acc;
      acc = ok && ad == 7'h15;
      @(posedge core_clk_i);
      token_i <= '{1'b1, id, n, ad, ok, 1'b1};
      @(posedge core_clk_i);
      token_i.valid <= 1'b0;
      #1 chk({31'h0, epv}, {31'h0, acc});
      if (acc) chk({27'h0, ep}, {27'h0, n == 4'h3, n});
   endtask : tok
   task automatic dpk(input logic bad);
      @(posedge core_clk_i);
      data_done_i <= 1'b1;
      data_crc16_bad_i <= bad;
      @(posedge core_clk_i);
      data_done_i <= 1'b0;
   endtask : dpk
   initial begin
      rst_i = 1'b1;
      {clk_en_i, reg_wr_i, reg_rd_i, data_done_i, data_crc16_bad_i} = 5'h10;
      reg_addr_i = 8'h0;
      reg_wdata_i = 32'h0;
      token_i = '0;
      repeat (2) @(posedge core_clk_i);
      #1 chk({28'h0, serial_ctrl_o}, 32'h2);
      chk({25'h0, otg_ctrl_o}, 32'h0);
      @(posedge core_clk_i);
      rst_i <= 1'b0;
      for (logic [7:0] a = 0; a <= 8'h40; a += 4) rdc(a, a == 8'h18 ? 32'h2 : 32'h0);
      for (int i = 0; i < 9; i++) begin
         v = $random(seed);
         e[i] = v & msk[i];
         wr(offs[i], v);
      end
      for (int i = 0; i < 9; i++) rdc(offs[i], e[i]);
      chk({25'h0, otg_ctrl_o}, {25'h0, e[1][7:6], e[1][4:0]});
      chk({28'h0, serial_ctrl_o}, {28'h0, e[2][3:0]});
      // read-only and unmapped offsets 0x14, 0x2C, 0x30, 0x40 ignore writes
      foreach (offs[i]) if (i < 4) wr(i == 0 ? 8'h14 : i == 3 ? 8'h40 : 8'h28 + 8'(i) * 8'h04, '1);
      foreach (offs[i]) if (i < 4) rdc(i == 0 ? 8'h14 : i == 3 ? 8'h40 : 8'h28 + 8'(i) * 8'h04, 32'h0);
      v = $random(seed);
      phy.set_lines(v[8:0]);
      repeat (4) @(posedge core_clk_i);
      rdc(8'h14, {26'h0, v[8:3]});
      rdc(8'h18, {25'h0, v[2:0], e[2][3:0]});
      wr(8'h08, 32'h15);
      wr(8'h20, 32'h0);
      wr(8'h24, 32'h04000040);
      wr(8'h34, 32'h8);
      wr(8'h1C, 32'h7F);
      tok(4'hD, 4'h3, 7'h15, 1'b1);
      tok(4'h9, 4'h3, 7'h16, 1'b1);
      tok(4'h9, 4'h3, 7'h15, 1'b0);
      tok(4'h1, 4'h5, 7'h15, 1'b1);
      rdc(8'h2C, 32'h1);
      rdc(8'h30, 32'h15);
      rdc(8'h1C, 32'h40);
      dpk(1'b0);
      rdc(8'h1C, 32'h40);
      dpk(1'b1);
      rdc(8'h1C, 32'h44);
      chk({28'h0, pa, pb, pc, pd}, 32'h9);
      phy.set_rx(1'b1, 1'b1);
      repeat (4) @(posedge core_clk_i);
      rdc(8'h1C, 32'h3);
      phy.set_rx(1'b0, 1'b0);
      repeat (4) @(posedge core_clk_i);
      rdc(8'h1C, 32'h0);
      wr(8'h20, 32'h44);
      tok(4'hD, 4'h5, 7'h15, 1'b1);
      dpk(1'b1);
      phy.set_rx(1'b1, 1'b0);
      repeat (4) @(posedge core_clk_i);
      phy.set_rx(1'b0, 1'b0);
      repeat (4) @(posedge core_clk_i);
      rdc(8'h1C, 32'h44);
      wr(8'h1C, 32'h40);
      rdc(8'h1C, 32'h4);
      fork
         wr(8'h1C, 32'h4);
         dpk(1'b1);
      join
      rdc(8'h1C, 32'h0);
      phy.set_ls(2'h2);
      wr(8'h20, 32'h0);
      wr(8'h04, 32'h4);
      repeat (4) @(posedge core_clk_i);
      rdc(8'h1C, 32'h10);
      phy.set_ls(2'h0);
      repeat (4) @(posedge core_clk_i);
      rdc(8'h1C, 32'h30);
      phy.set_ls(2'h1);
      repeat (4) @(posedge core_clk_i);
      rdc(8'h1C, 32'h38);
      @(posedge core_clk_i);
      clk_en_i <= 1'b0;
      wr(8'h28, 32'h5);
      clk_en_i <= 1'b1;
      rdc(8'h28, e[5]);
      wr(8'h28, '1);
      rdc(8'h28, 32'h7FF);
      @(posedge core_clk_i);
      rst_i <= 1'b1;
      @(posedge core_clk_i);
      rst_i <= 1'b0;
      rdc(8'h10, 32'h0);
      chk({28'h0, serial_ctrl_o}, 32'h2);
      close_out();
   end
endmodule : uim_regs_tb_top
